// ==== hdl/tat_pkg.sv ====
package tat_pkg;
  // ==========================================================================
  // Register map
  localparam logic [7:0]  ADDR_UPPER    = 8'h02;
  localparam logic [7:0]  ADDR_LOWER    = 8'h03;
  localparam logic [7:0]  ADDR_CRIT     = 8'h04;
  // ==========================================================================
  // Field layout of a limit register
  localparam int          LIM_MSB       = 12;
  localparam int          LIM_LSB       = 2;
  localparam int          LIM_W         = 11;
  localparam logic [15:0] LIM_MASK      = 16'h1ffc;
  localparam logic [15:0] LIM_RESET     = 16'h0000;
  // Configuration lock bit positions
  localparam int          CFG_WIN_LOCK  = 6;
  localparam int          CFG_CRIT_LOCK = 7;
  // Temperature and hysteresis width, both in 1/8 degree steps
  localparam int          TEMP_W        = 12;

  // Register write request
  typedef struct packed {
    logic        wr;
    logic [7:0]  addr;
    logic [15:0] data;
  } tat_wr_s;

  // Trip status flags
  typedef struct packed {
    logic crit;
    logic high;
    logic low;
  } tat_trip_s;
endpackage : tat_pkg

// ==== hdl/tat_trip_cmp.sv ====
`timescale 1ns/1ps
// ============================================================================
// Single limit comparator with hysteresis, temperature in 1/8 degree steps
module tat_trip_cmp (
  input  wire logic                    ref_clk,
  input  wire logic                    srst,
  input  wire logic                    below_mode,
  input  wire logic signed [11:0]      temp,
  input  wire logic signed [11:0]      limit,
  input  wire logic        [11:0]      hyst,
  output logic                         trip
);
  logic signed [13:0] lim_ext;
  logic signed [13:0] lim_hys;
  logic signed [13:0] tmp_ext;
  logic               next_trip;

  // Two extra sign bits so a low limit minus a large hysteresis cannot wrap
  assign lim_ext = {{2{limit[11]}}, limit};
  assign lim_hys = lim_ext - $signed({2'b00, hyst});
  assign tmp_ext = {{2{temp[11]}}, temp};

  // Set and release points, high trip or low trip
  assign next_trip = below_mode
    ? (trip ? (tmp_ext < lim_ext) : (tmp_ext < lim_hys))
    : (trip ? (tmp_ext > lim_hys) : (tmp_ext > lim_ext));

  // Trip state
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      trip <= 1'b0;
    else
      trip <= next_trip;
  end
endmodule : tat_trip_cmp

// ==== hdl/tat_limit_regs.sv ====
`timescale 1ns/1ps
module tat_limit_regs (
  input  wire logic                ref_clk,
  input  wire logic                srst,
  input  wire tat_pkg::tat_wr_s    wr_req,
  input  wire logic [7:0]          rd_addr,
  output logic      [15:0]         rd_data,
  output logic                     rd_hit,
  input  wire logic                window_lock,
  input  wire logic                critical_lock,
  input  wire logic                alarm_enable,
  input  wire logic                critical_only,
  input  wire logic signed [11:0]  temp,
  input  wire logic        [11:0]  hyst,
  output tat_pkg::tat_trip_s       trip,
  output logic                     alarm
);
  // ==========================================================================
  // Constants and internal signals
  // Entry order of the per-limit arrays, in register address order
  localparam int   N_LIM      = 3;
  localparam int   E_UPPER    = 0;
  localparam int   E_LOWER    = 1;
  localparam int   E_CRIT     = 2;
  // Trip direction of a comparator
  localparam logic TRIP_ABOVE = 1'b0;
  localparam logic TRIP_BELOW = 1'b1;

  // Stored limits, one entry per register
  logic [15:0]        lim_q [N_LIM];
  logic [15:0]        upper_limit;
  logic [15:0]        lower_limit;
  logic [15:0]        critical_limit;

  // Write side decode and strobes
  logic               sel_upper;
  logic               sel_lower;
  logic               sel_crit;
  logic               upper_open;
  logic               lower_open;
  logic               crit_open;
  logic               wr_upper;
  logic               wr_lower;
  logic               wr_crit;
  logic [N_LIM-1:0]   lim_wr;
  logic [15:0]        wr_val;

  // Read side decode
  logic               rsel_upper;
  logic               rsel_lower;
  logic               rsel_crit;
  logic [15:0]        next_rd_data;

  // Limits on the temperature scale, trip states and alarm terms
  logic signed [11:0] lim_val [N_LIM];
  logic signed [11:0] upper_limit_value;
  logic signed [11:0] lower_limit_value;
  logic signed [11:0] critical_limit_value;
  logic               trip_high;
  logic               trip_low;
  logic               trip_crit;
  logic               window_trip;
  logic               window_alarm;
  logic               next_alarm;

  // ==========================================================================
  // Write decode, writes and reads decode their own address
  assign sel_upper = (wr_req.addr == tat_pkg::ADDR_UPPER);
  assign sel_lower = (wr_req.addr == tat_pkg::ADDR_LOWER);
  assign sel_crit  = (wr_req.addr == tat_pkg::ADDR_CRIT);
  // A refused write is dropped silently, the entry keeps its value
  assign wr_upper = wr_req.wr && sel_upper && upper_open;
  assign wr_lower = wr_req.wr && sel_lower && lower_open;
  assign wr_crit  = wr_req.wr && sel_crit  && crit_open;
  assign lim_wr   = {wr_crit, wr_lower, wr_upper};
  // Data offered to every entry, reserved bits cleared
  // reserved bits dropped
  assign wr_val   = wr_req.data & tat_pkg::LIM_MASK;

  // ==========================================================================
  // Lock gating, the lock inputs gate writes directly, reset does not clear them
  // window and critical lock gates
  assign upper_open = !window_lock;
  assign lower_open = !window_lock;
  assign crit_open  = !critical_lock;

  // ==========================================================================
  // Limit storage
  // upper, lower and critical storage
  // reset zero, locked write ignored
  // Reset wins over a write in the same cycle
  generate
    for (genvar i = 0; i < N_LIM; i++)
    begin : g_lim
      // Entry register, loaded only by its own accepted write
      always_ff @(posedge ref_clk)
      begin
        if (srst)
          lim_q[i] <= tat_pkg::LIM_RESET;
        else if (lim_wr[i])
          lim_q[i] <= wr_val;
      end
      // quarter degree limit onto 1/8 degree scale
      // Appending a zero keeps the sign bit on top
      assign lim_val[i] = {lim_q[i][tat_pkg::LIM_MSB:tat_pkg::LIM_LSB], 1'b0};
    end
  endgenerate

  // Register views for the read path
  assign upper_limit    = lim_q[E_UPPER];
  assign lower_limit    = lim_q[E_LOWER];
  assign critical_limit = lim_q[E_CRIT];
  // Limit views for the comparators
  assign upper_limit_value    = lim_val[E_UPPER];
  assign lower_limit_value    = lim_val[E_LOWER];
  assign critical_limit_value = lim_val[E_CRIT];

  // ==========================================================================
  // Read decode
  assign rsel_upper = (rd_addr == tat_pkg::ADDR_UPPER);
  assign rsel_lower = (rd_addr == tat_pkg::ADDR_LOWER);
  assign rsel_crit  = (rd_addr == tat_pkg::ADDR_CRIT);
  assign rd_hit     = rsel_upper || rsel_lower || rsel_crit;

  // ==========================================================================
  // Read data, unmapped addresses read zero
  // One-hot selects, OR of the masked entries
  assign next_rd_data = ({16{rsel_upper}} & upper_limit)
                      | ({16{rsel_lower}} & lower_limit)
                      | ({16{rsel_crit}}  & critical_limit);

  // Registered read data, one cycle after the address
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      rd_data <= 16'h0000;
    else
      rd_data <= next_rd_data;
  end

  // ==========================================================================
  // Trip comparators, temperature in 1/8 degree steps
  // Hysteresis moves the release point of the upper and critical trips, but the set point of the lower trip
  // upper trip with hysteresis
  tat_trip_cmp u_upper (
    .ref_clk    (ref_clk),
    .srst       (srst),
    .below_mode (TRIP_ABOVE),
    .temp       (temp),
    .limit      (upper_limit_value),
    .hyst       (hyst),
    .trip       (trip_high)
  );

  tat_trip_cmp u_lower (
    .ref_clk    (ref_clk),
    .srst       (srst),
    .below_mode (TRIP_BELOW),
    .temp       (temp),
    .limit      (lower_limit_value),
    .hyst       (hyst),
    .trip       (trip_low)
  );

  tat_trip_cmp u_crit (
    .ref_clk    (ref_clk),
    .srst       (srst),
    .below_mode (TRIP_ABOVE),
    .temp       (temp),
    .limit      (critical_limit_value),
    .hyst       (hyst),
    .trip       (trip_crit)
  );

  // ==========================================================================
  // Alarm combine
  // Window alarm from either window trip
  assign window_trip  = trip_high || trip_low;
  // Critical only mode masks the window alarm
  assign window_alarm = !critical_only && window_trip;
  assign next_alarm   = alarm_enable && (trip_crit || window_alarm);
  // Trip states as seen by the status bits outside
  assign trip         = '{crit: trip_crit, high: trip_high, low: trip_low};

  // Registered alarm, polarity and mode are applied outside
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      alarm <= 1'b0;
    else
      alarm <= next_alarm;
  end
endmodule : tat_limit_regs

// ==== verification/tat_limit_regs_checker.sv ====
`timescale 1ns/1ps
// ==========================================================================
// Port checker for the limit register bank
module tat_checker (
  input wire logic               ref_clk,
  input wire logic               srst,
  input wire tat_pkg::tat_wr_s   wr_req,
  input wire logic [7:0]         rd_addr,
  input wire logic [15:0]        rd_data,
  input wire logic               rd_hit,
  input wire logic               window_lock,
  input wire logic               critical_lock,
  input wire logic               alarm_enable,
  input wire logic               critical_only,
  input wire logic signed [11:0] temp,
  input wire logic [11:0]        hyst,
  input wire tat_pkg::tat_trip_s trip,
  input wire logic               alarm
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  AST_UNMAPPED: assert property (!rd_hit |=> rd_data == 16'h0000)
    else $error("unmapped read not zero");
  AST_RSV: assert property (rd_data[15:13] == 3'h0 && rd_data[1:0] == 2'h0)
    else $error("reserved bits not zero");
  AST_UP_LOCK: assert property (window_lock && rd_addr == tat_pkg::ADDR_UPPER ##1
    rd_addr == tat_pkg::ADDR_UPPER |=> $stable(rd_data)) else $error("upper changed under lock");
  AST_LO_LOCK: assert property (window_lock && rd_addr == tat_pkg::ADDR_LOWER ##1
    rd_addr == tat_pkg::ADDR_LOWER |=> $stable(rd_data)) else $error("lower changed under lock");
  AST_CR_LOCK: assert property (critical_lock && rd_addr == tat_pkg::ADDR_CRIT ##1
    rd_addr == tat_pkg::ADDR_CRIT |=> $stable(rd_data)) else $error("crit changed under lock");
  AST_RST: assert property ($fell(srst) |-> rd_data == 16'h0000 && trip == 3'h0 && !alarm)
    else $error("state not clear after reset");
  AST_ALM_OFF: assert property (!alarm_enable |=> !alarm)
    else $error("alarm while disabled");
  AST_ALM_CRIT: assert property (alarm_enable && critical_only |=> alarm == $past(trip.crit))
    else $error("alarm does not follow critical trip");
  cover property (wr_req.wr && window_lock);
  cover property (trip.low && alarm);
  cover property ($rose(trip.crit));
endmodule : tat_checker

// ==== verification/tat_host.sv ====
`timescale 1ns/1ps
// ==========================================================================
// Host stand-in driving writes and reads
module tat_host (
  input  wire logic        ref_clk,
  input  wire logic [15:0] rd_data,
  output tat_pkg::tat_wr_s wr_req,
  output logic [7:0]       rd_addr
);
  // Idle values at time zero
  initial wr_req = '0;
  initial rd_addr = 8'h00;
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    #1 wr_req = '{wr: 1'b1, addr: a, data: d};
    @(posedge ref_clk);
    #1 wr_req.wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    #1 rd_addr = a;
    repeat (2) @(posedge ref_clk);
    #1 d = rd_data;
  endtask : rd
endmodule : tat_host

// ==== verification/thermal_alarm_trip_registers_tb_top.sv ====
`timescale 1ns/1ps
// ==========================================================================
// Self-checking bench for the limit register bank
module thermal_alarm_trip_registers_tb_top;
  logic ref_clk = 1'b0, srst = 1'b1, window_lock = 1'b0, critical_lock = 1'b0;
  logic alarm_enable = 1'b0, critical_only = 1'b0, rd_hit, alarm;
  logic signed [11:0] temp = 12'h000;
  logic [11:0] hyst = 12'h000;
  logic [15:0] rd_data, d;
  logic [7:0] rd_addr;
  tat_pkg::tat_wr_s wr_req;
  tat_pkg::tat_trip_s trip;
  int n_mismatch = 0, cmp_count = 0, cyc = 0;
  always #5 ref_clk = ~ref_clk;
  tat_limit_regs u_dut (.ref_clk(ref_clk), .srst(srst), .wr_req(wr_req), .rd_addr(rd_addr),
    .rd_data(rd_data), .rd_hit(rd_hit), .window_lock(window_lock), .critical_lock(critical_lock),
    .alarm_enable(alarm_enable), .critical_only(critical_only), .temp(temp), .hyst(hyst),
    .trip(trip), .alarm(alarm));
  tat_host u_host (.ref_clk(ref_clk), .rd_data(rd_data), .wr_req(wr_req), .rd_addr(rd_addr));
  task chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task rdc(input logic [7:0] a, input logic [15:0] exp);
    u_host.rd(a, d);
    chk(d, exp);
    chk({15'h0000, rd_hit}, {15'h0000, (a >= 8'h02) && (a <= 8'h04)});
  endtask : rdc
  // New temperature, then trip and alarm two edges later as {alarm,crit,high,low}
  task tmp(input logic [11:0] t, input logic [3:0] exp);
    @(posedge ref_clk);
    #1 temp = t;
    repeat (2) @(posedge ref_clk);
    #1 chk({12'h000, alarm, trip}, {12'h000, exp});
  endtask : tmp
  task test_done;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : test_done
  // Hang guard
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_mismatch++;
      test_done();
    end
  end
  // Main sequence
  initial
  begin
    repeat (20) @(posedge ref_clk);
    #1 srst = 1'b0;
    rdc(8'h02, 16'h0000);
    rdc(8'h03, 16'h0000);
    rdc(8'h04, 16'h0000);
    rdc(8'h05, 16'h0000);
    u_host.wr(8'h02, 16'hffff);
    rdc(8'h02, 16'h1ffc);
    u_host.wr(8'h03, 16'h1ec0);
    rdc(8'h03, 16'h1ec0);
    u_host.wr(8'h04, 16'h07d0);
    rdc(8'h04, 16'h07d0);
    u_host.wr(8'h02, 16'h0550);
    rdc(8'h02, 16'h0550);
    $display("register test done");
    alarm_enable = 1'b1;
    tmp(12'h2a9, 4'ha);
    tmp(12'h2a8, 4'h0);
    hyst = 12'h008;
    tmp(12'hf58, 4'h0);
    tmp(12'hf57, 4'h9);
    tmp(12'hf5f, 4'h9);
    tmp(12'hf60, 4'h0);
    critical_only = 1'b1;
    tmp(12'h3e9, 4'he);
    tmp(12'h3e1, 4'he);
    tmp(12'h3e0, 4'h2);
    $display("trip test done");
    window_lock = 1'b1;
    u_host.wr(8'h02, 16'h0000);
    rdc(8'h02, 16'h0550);
    u_host.wr(8'h03, 16'h0000);
    rdc(8'h03, 16'h1ec0);
    u_host.wr(8'h04, 16'h0640);
    rdc(8'h04, 16'h0640);
    critical_lock = 1'b1;
    u_host.wr(8'h04, 16'h0000);
    rdc(8'h04, 16'h0640);
    $display("lock test done");
    // Mid-run reset clears limits, trips and alarm
    @(posedge ref_clk);
    #1 srst = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1 srst = 1'b0;
    chk({13'h0000, trip}, 16'h0000);
    rdc(8'h04, 16'h0000);
    rdc(8'h02, 16'h0000);
    $display("reset test done");
    test_done();
  end
endmodule : thermal_alarm_trip_registers_tb_top
bind tat_limit_regs tat_checker u_chk (.ref_clk(ref_clk), .srst(srst), .wr_req(wr_req),
  .rd_addr(rd_addr), .rd_data(rd_data), .rd_hit(rd_hit), .window_lock(window_lock),
  .critical_lock(critical_lock), .alarm_enable(alarm_enable), .critical_only(critical_only),
  .temp(temp), .hyst(hyst), .trip(trip), .alarm(alarm));
